// [src/hal_link.sv]
// auto-mode link procedure engine of one hdlc channel
// assumes a framer on clk_in: it reports parsed frames and sends what we request
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps
module hal_link #(
    parameter int TICK = hal_pkg::TICK_CYC
) (
    input  wire logic               clk_in,
    input  wire logic               rst_b_in,
    input  wire logic [7:0]         reg_addr_in,
    input  wire logic [7:0]         reg_wdata_in,
    input  wire logic               reg_wr_in,
    input  wire logic               reg_rd_in,
    output logic [7:0]              reg_rdata_out,
    input  wire logic               rx_valid_in,
    input  wire hal_pkg::hal_frame_t rx_frame_in,
    output logic                    rx_store_out,
    output logic                    tx_start_out,
    output hal_pkg::hal_frame_t     tx_frame_out,
    input  wire logic               tx_done_in,
    output logic                    ctrl_ext_out,
    output logic                    queue_locked_out,
    output hal_pkg::hal_irq_t       irq_out
);
    localparam int RESP_MAX = hal_pkg::RESP_MAX_CYC;

    hal_pkg::hal_state_t r;
    hal_pkg::hal_state_t n;
    hal_pkg::hal_frame_t f;
    hal_pkg::hal_frame_t fr;
    logic                auto_m;
    logic                tint;
    logic                normal_response_mode_bit;
    logic                ext;
    logic                lbusy;
    logic                acked;
    logic                tmr_start;
    logic                tmr_run;
    logic                tmr_exp;
    logic                link_rst;

    assign auto_m = (r.mode[hal_pkg::MODE_MDS_HI:hal_pkg::MODE_MDS_LO] == 2'h0);
    assign tint   = r.mode[hal_pkg::MODE_TINT];
    assign lbusy  = r.mode[hal_pkg::MODE_LBUSY];
    assign normal_response_mode_bit    = r.bch[hal_pkg::BCH_NRM];
    assign ext    = r.second_high_address_compare[hal_pkg::SECOND_HIGH_ADDRESS_COMPARE_EXT];
    assign f      = rx_frame_in;
    assign link_rst = reg_wr_in && (reg_addr_in == hal_pkg::A_CMD)
                      && reg_wdata_in[hal_pkg::CMD_RST];
    // window of one: only the low bit of the counters matters
    assign acked  = (f.nr[0] == r.vs[0]);
    // a secondary never runs the timer on its own
    assign tmr_run = (r.q_locked && tint && !normal_response_mode_bit) || r.busy_poll;

    hal_timer #(
        .TICK(TICK)
    ) u_timer (
        .clk_in     (clk_in),
        .rst_b_in   (rst_b_in),
        .start_in   (tmr_start),
        .run_in     (tmr_run),
        .period_in  (r.per),
        .expired_out(tmr_exp)
    );

    always_comb begin
        n = r;
        fr = '0;
        tmr_start = 1'b0;
        n.tx_start = 1'b0;
        n.rx_store = 1'b0;
        n.irq = '0;
        n.rdata = 8'h00;
        if (reg_wr_in) begin
            case (reg_addr_in)
                hal_pkg::A_MODE: n.mode = reg_wdata_in;
                hal_pkg::A_CMD: begin
                    if (reg_wdata_in[hal_pkg::CMD_XI] && auto_m) begin
                        n.i_pend = 1'b1;
                    end
                    if (reg_wdata_in[hal_pkg::CMD_XT]) begin
                        n.t_pend = 1'b1;
                    end
                end
                hal_pkg::A_BCH:  n.bch = reg_wdata_in;
                hal_pkg::A_SECOND_HIGH_ADDRESS_COMPARE: n.second_high_address_compare = reg_wdata_in;
                hal_pkg::A_PER:  n.per = reg_wdata_in;
                hal_pkg::A_RTY:  n.rty = reg_wdata_in;
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                hal_pkg::A_MODE: n.rdata = r.mode;
                hal_pkg::A_BCH:  n.rdata = r.bch;
                hal_pkg::A_SECOND_HIGH_ADDRESS_COMPARE: n.rdata = r.second_high_address_compare;
                hal_pkg::A_PER:  n.rdata = r.per;
                hal_pkg::A_RTY:  n.rdata = r.rty;
                hal_pkg::A_STAT: n.rdata = {1'b0, r.grant, r.t_pend, r.i_pend,
                                            r.wait_final, r.busy_poll,
                                            r.remote_busy, r.q_locked};
                hal_pkg::A_VS:   n.rdata = {1'b0, r.vs};
                hal_pkg::A_VR:   n.rdata = {1'b0, r.vr};
                default:         n.rdata = 8'h00;
            endcase
        end
        if (tx_done_in) begin
            case (r.st)
                hal_pkg::TX_I: begin
                    n.q_locked = 1'b1;
                    n.vs = hal_pkg::hal_inc(r.vs, ext);
                    n.tries = 8'h00;
                    n.wait_final = 1'b0;
                    if (tint && !normal_response_mode_bit) begin
                        tmr_start = 1'b1;
                    end
                end
                hal_pkg::TX_T: n.irq.pool_ready = 1'b1;
                default: ;
            endcase
            n.st = hal_pkg::TX_IDLE;
        end
        if (r.st == hal_pkg::TX_IDLE && !r.tx_start) begin
            fr.ns = r.vs;
            fr.nr = r.vr;
            fr.sfunc = lbusy ? hal_pkg::S_RNR : hal_pkg::S_RR;
            if (r.s_cmd && !normal_response_mode_bit) begin
                fr.kind = hal_pkg::K_S;
                fr.pf = 1'b1;
                fr.is_cmd = 1'b1;
                n.s_cmd = 1'b0;
                n.st = hal_pkg::TX_S;
            end else if (normal_response_mode_bit && r.grant && r.t_pend) begin
                fr.kind = hal_pkg::K_T;
                fr.pf = 1'b1;
                n.t_pend = 1'b0;
                n.s_pend = 1'b0;
                n.st = hal_pkg::TX_T;
            end else if (normal_response_mode_bit && r.grant && r.i_pend && !r.q_locked) begin
                fr.kind = hal_pkg::K_I;
                fr.pf = 1'b1;
                n.i_pend = 1'b0;
                n.s_pend = 1'b0;
                n.st = hal_pkg::TX_I;
            end else if (r.s_pend && (!normal_response_mode_bit || r.grant)) begin
                fr.kind = hal_pkg::K_S;
                fr.pf = r.s_pf;
                n.s_pend = 1'b0;
                n.st = hal_pkg::TX_S;
            end else if (!normal_response_mode_bit && r.t_pend) begin
                fr.kind = hal_pkg::K_T;
                n.t_pend = 1'b0;
                n.st = hal_pkg::TX_T;
            end else if (!normal_response_mode_bit && r.i_pend && !r.q_locked && !r.remote_busy
                         && tint && auto_m) begin
                fr.kind = hal_pkg::K_I;
                fr.is_cmd = 1'b1;
                n.i_pend = 1'b0;
                n.st = hal_pkg::TX_I;
            end
            if (n.st != hal_pkg::TX_IDLE) begin
                n.tx_start = 1'b1;
                n.tx_frame = fr;
                n.grant = 1'b0;
            end
        end
        // timer work comes before receive so a late ack still wins
        if (tmr_exp && !normal_response_mode_bit) begin
            if (r.tries == r.rty) begin
                n.irq.timer_expiry = r.q_locked || r.busy_poll;
                n.q_locked = 1'b0;
                n.busy_poll = 1'b0;
                n.wait_final = 1'b0;
            end else begin
                n.s_cmd = 1'b1;
                n.wait_final = 1'b1;
                n.tries = r.tries + 8'h01;
            end
        end
        if (rx_valid_in) begin
            if (!auto_m) begin
                n.rx_store = 1'b1;
            end else if (f.kind == hal_pkg::K_I || (f.kind == hal_pkg::K_S && !f.has_info)) begin
                if (r.q_locked) begin
                    if (acked) begin
                        n.q_locked = 1'b0;
                        n.wait_final = 1'b0;
                        n.irq.pool_ready = 1'b1;
                    end else if ((f.kind == hal_pkg::K_S && f.sfunc == hal_pkg::S_REJ)
                                 || (f.pf && !f.is_cmd && r.wait_final)
                                 || (normal_response_mode_bit && f.pf)) begin
                        n.q_locked = 1'b0;
                        n.wait_final = 1'b0;
                        n.irq.repeat_needed = 1'b1;
                    end
                end else if (!acked) begin
                    n.irq.protocol_error = 1'b1;
                end
            end
            if (auto_m) begin
                case (f.kind)
                    hal_pkg::K_U: n.rx_store = 1'b1;
                    hal_pkg::K_S: begin
                        if (f.has_info) begin
                            n.irq.protocol_error = 1'b1;
                        end else begin
                            if (f.sfunc != hal_pkg::S_REJ) begin
                                n.remote_busy = (f.sfunc == hal_pkg::S_RNR);
                                n.irq.remote_status = (f.sfunc == hal_pkg::S_RNR)
                                                      != r.remote_busy;
                            end
                            if (f.sfunc == hal_pkg::S_RNR && !r.busy_poll
                                && tint && !normal_response_mode_bit) begin
                                n.busy_poll = 1'b1;
                                n.tries = 8'h00;
                                tmr_start = 1'b1;
                            end
                            if (f.sfunc == hal_pkg::S_RR) begin
                                n.busy_poll = 1'b0;
                            end
                            if (f.pf && !f.is_cmd) begin
                                n.wait_final = 1'b0;
                            end
                            if (f.pf && f.is_cmd) begin
                                n.s_pend = 1'b1;
                                n.s_pf = 1'b1;
                                n.grant = normal_response_mode_bit;
                            end
                        end
                    end
                    hal_pkg::K_I: begin
                        n.s_pend = !normal_response_mode_bit || f.pf;
                        n.s_pf = f.pf;
                        if (!lbusy && f.ns[0] == r.vr[0]) begin
                            n.rx_store = 1'b1;
                            n.vr = hal_pkg::hal_inc(r.vr, ext);
                        end
                        if (normal_response_mode_bit && f.pf) begin
                            n.grant = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (link_rst) begin
            n.vs = 7'h00;
            n.vr = 7'h00;
            n.q_locked = 1'b0;
            n.remote_busy = 1'b0;
            n.wait_final = 1'b0;
            n.busy_poll = 1'b0;
            n.s_pend = 1'b0;
            n.s_cmd = 1'b0;
            n.grant = 1'b0;
            n.i_pend = 1'b0;
            n.t_pend = 1'b0;
            n.tries = 8'h00;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            r <= '0;
            r.st <= hal_pkg::TX_IDLE;
            r.mode <= hal_pkg::RST_MODE;
            r.bch <= hal_pkg::RST_BCH;
            r.second_high_address_compare <= hal_pkg::RST_SECOND_HIGH_ADDRESS_COMPARE;
            r.per <= hal_pkg::RST_PER;
            r.rty <= hal_pkg::RST_RTY;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata_out    = r.rdata;
    assign rx_store_out     = r.rx_store;
    assign tx_start_out     = r.tx_start;
    assign tx_frame_out     = r.tx_frame;
    assign ctrl_ext_out     = ext;
    assign queue_locked_out = r.q_locked;
    assign irq_out          = r.irq;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    AST_I_AUTO_ONLY: assert property (
        tx_start_out && tx_frame_out.kind == hal_pkg::K_I |-> $past(auto_m))
        else $error("i-frame sent outside auto-mode");
    AST_U_STORED: assert property (
        rx_valid_in && auto_m && f.kind == hal_pkg::K_U |=> rx_store_out)
        else $error("unnumbered frame not stored");
    AST_LINK_RESET: assert property (
        link_rst |=> r.vs == 7'h00 && r.vr == 7'h00 && !queue_locked_out)
        else $error("link reset left state");
    AST_S_INFO_ERR: assert property (
        rx_valid_in && auto_m && f.kind == hal_pkg::K_S && f.has_info
        |=> irq_out.protocol_error && !irq_out.pool_ready && !rx_store_out)
        else $error("s-frame with info not flagged");
    AST_NS_DISCARD: assert property (
        rx_valid_in && auto_m && !normal_response_mode_bit && !link_rst && f.kind == hal_pkg::K_I
        && f.ns[0] != r.vr[0] |=> !rx_store_out && r.s_pend && $stable(r.vr))
        else $error("out of sequence i-frame not discarded");
    AST_BUSY_REJECT: assert property (
        rx_valid_in && auto_m && !normal_response_mode_bit && !link_rst && lbusy && f.kind == hal_pkg::K_I
        |=> !rx_store_out && r.s_pend && !irq_out.protocol_error[*1])
        else $error("i-frame taken while busy");
    AST_I_LOCKS: assert property (
        tx_done_in && r.st == hal_pkg::TX_I && !link_rst
        |=> queue_locked_out && r.vs != $past(r.vs))
        else $error("queue not locked after i-frame");
    AST_T_UNLOCK: assert property (
        tx_done_in && r.st == hal_pkg::TX_T |=> irq_out.pool_ready)
        else $error("transparent frame not confirmed");
    AST_NRM_RESP: assert property (
        tx_start_out && normal_response_mode_bit |-> !tx_frame_out.is_cmd && $past(r.grant))
        else $error("secondary sent without grant");
    AST_RESP_5: assert property (
        rx_valid_in && auto_m && !normal_response_mode_bit && f.kind == hal_pkg::K_S && !f.has_info
        && f.is_cmd && f.pf && r.st == hal_pkg::TX_IDLE && !r.tx_start && !r.s_cmd
        && !tmr_exp && !reg_wr_in && !tx_done_in |-> ##[1:RESP_MAX] tx_start_out)
        else $error("poll not answered in time");

    COV_I_ACKED: cover property (
        tx_done_in && r.st == hal_pkg::TX_I ##[1:200] irq_out.pool_ready);
    COV_TIMEOUT: cover property (irq_out.timer_expiry);
    COV_REPEAT: cover property (irq_out.repeat_needed);
    COV_NRM_TX: cover property (tx_start_out && normal_response_mode_bit && tx_frame_out.kind == hal_pkg::K_I);
endmodule : hal_link

// [src/hal_pkg.sv]
// constants, carriers and state of the hdlc auto-mode link engine
// assumes a framer on the same clock that builds and parses the frames
// How it works
// - send_info_frame_cmd builds address and control itself, info from queue; auto-mode only.
// - send_transparent_frame_cmd sends software-built frame from queue in every mode.
// - window size one; modulo 8 or 128 chosen by second_high_address_compare bit.
// - auto-mode stores every received unnumbered frame in the receive queue.
// - link_reset_cmd reinitialises the logical link state at any time.
// - after reset the channel is a combined station doing auto procedures.
// - s-frames handled silently; events only on ready change, protocol error or a queue unlock (pool ready or repeat).
// - i-frame with unexpected send number discarded silently, answered by s response.
// - while software holds receiver busy, i-frames rejected silently with rnr.
// - sequence checks use only the least significant bit of the counters.
// - device builds all s commands and responses; user sends i or transparent.
// - i-frame needs internal timer; after sending start timer, lock queue, await ack.
// - on timeout poll with p set, expect f set; retry count times, then stop.
// - ack or poll end unlocks queue with pool ready, repeat or timer expiry.
// - after rnr, poll every period until ready; after retries, timer expiry.
// - transparent frame sent unlocks queue at once with pool ready.
// - normal response mode bit makes a secondary answering only after a poll.
// - secondary holds i-frame until polled, sends with final, locks until acked.
// - secondary unlocks on ack with pool ready or repeat; never polls.
// - secondary sends transparent frame only after a poll grant.
// - auto-mode when both mode select bits are zero.
// - response frame starts within five cycles after a frame is received.
package hal_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESP_MAX_CYC  = 5;

    localparam logic [7:0] A_MODE = 8'h00;
    localparam logic [7:0] A_CMD  = 8'h04;
    localparam logic [7:0] A_BCH  = 8'h08;
    localparam logic [7:0] A_SECOND_HIGH_ADDRESS_COMPARE = 8'h0C;
    localparam logic [7:0] A_PER  = 8'h10;
    localparam logic [7:0] A_RTY  = 8'h14;
    localparam logic [7:0] A_STAT = 8'h18;
    localparam logic [7:0] A_VS   = 8'h1C;
    localparam logic [7:0] A_VR   = 8'h20;

    localparam int MODE_MDS_LO = 0;
    localparam int MODE_MDS_HI = 1;
    localparam int MODE_ADM    = 2;
    localparam int MODE_TINT   = 3;
    localparam int MODE_LBUSY  = 4;
    localparam int CMD_XI      = 0;
    localparam int CMD_XT      = 1;
    localparam int CMD_RST     = 2;
    localparam int BCH_NRM     = 5;
    localparam int SECOND_HIGH_ADDRESS_COMPARE_EXT    = 0;

    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_BCH  = 8'h00;
    localparam logic [7:0] RST_SECOND_HIGH_ADDRESS_COMPARE = 8'h00;
    localparam logic [7:0] RST_PER  = 8'h0A;
    localparam logic [7:0] RST_RTY  = 8'h03;

    localparam logic [1:0] K_I   = 2'h0;
    localparam logic [1:0] K_S   = 2'h1;
    localparam logic [1:0] K_U   = 2'h2;
    localparam logic [1:0] K_T   = 2'h3;
    localparam logic [1:0] S_RR  = 2'h0;
    localparam logic [1:0] S_RNR = 2'h1;
    localparam logic [1:0] S_REJ = 2'h2;

    typedef struct packed {
        logic [1:0] kind;
        logic [1:0] sfunc;
        logic [6:0] ns;
        logic [6:0] nr;
        logic       pf;
        logic       is_cmd;
        logic       has_info;
    } hal_frame_t;

    typedef struct packed {
        logic pool_ready;
        logic repeat_needed;
        logic timer_expiry;
        logic remote_status;
        logic protocol_error;
    } hal_irq_t;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_I    = 4'h2,
        TX_T    = 4'h4,
        TX_S    = 4'h8
    } hal_tx_st_t;

    typedef struct packed {
        hal_tx_st_t st;
        logic [7:0] mode, bch, second_high_address_compare, per, rty, rdata, tries;
        logic [6:0] vs, vr;
        logic       q_locked, remote_busy, wait_final, busy_poll;
        logic       s_pend, s_pf, s_cmd, grant, i_pend, t_pend;
        logic       tx_start, rx_store;
        hal_frame_t tx_frame;
        hal_irq_t   irq;
    } hal_state_t;

    function automatic logic [6:0] hal_inc(input logic [6:0] v, input logic ext);
        return ext ? v + 7'h01 : {4'h0, v[2:0] + 3'h1};
    endfunction : hal_inc
endpackage : hal_pkg

// [src/hal_timer.sv]
// supervision timer: counts period ticks, pulses on every expiry while run
// assumes start and run come from logic on the same clock
`timescale 1ns/100ps
module hal_timer #(
    parameter int TICK = hal_pkg::TICK_CYC
) (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       start_in,
    input  wire logic       run_in,
    input  wire logic [7:0] period_in,
    output logic            expired_out
);
    typedef struct packed {
        logic [15:0] tick;
        logic [7:0]  cnt;
        logic        exp;
    } hal_tmr_t;

    hal_tmr_t r;
    hal_tmr_t n;

    always_comb begin
        n = r;
        n.exp = 1'b0;
        if (start_in) begin
            n.tick = 16'h0000;
            n.cnt = 8'h00;
        end else if (run_in) begin
            if (r.tick == 16'(TICK - 1)) begin
                n.tick = 16'h0000;
                // a zero period behaves as one tick
                if ({1'b0, r.cnt} + 9'h001 >= {1'b0, period_in}) begin
                    n.cnt = 8'h00;
                    n.exp = 1'b1;
                end else begin
                    n.cnt = r.cnt + 8'h01;
                end
            end else begin
                n.tick = r.tick + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign expired_out = r.exp;
endmodule : hal_timer

// [test/hal_framer_model.sv]
// far-side framer model: returns one done pulse for every frame it is asked to send
// assumes the link engine keeps at most one frame in flight
`timescale 1ns/100ps
module hal_framer_model (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       tx_start_in,
    input  wire logic [3:0] dly_in,
    output logic            tx_done_out
);
    logic [4:0] cnt_r;

    // dly_in lets the bench answer promptly or slowly
    always @(posedge clk_in) begin
        tx_done_out <= 1'b0;
        if (!rst_b_in) begin
            cnt_r <= 5'h00;
        end else if (tx_start_in) begin
            cnt_r <= {1'b0, dly_in} + 5'h01;
        end else if (cnt_r != 5'h00) begin
            cnt_r       <= cnt_r - 5'h01;
            tx_done_out <= (cnt_r == 5'h01);
        end
    end
endmodule : hal_framer_model

// [test/tb_hdlc_auto_mode_link_procedure.sv]
// self-checking bench of the auto-mode link engine with a framer model
// assumes TICK shortened to 2 cycles so timer periods stay short
`timescale 1ns/100ps
module tb_hdlc_auto_mode_link_procedure;
    localparam int TK = 2;
    logic clk_in = 1'b0, rst_b_in = 1'b0, wr = 1'b0, rd = 1'b0, rxv = 1'b0;
    logic done, start, store, ext, lock;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, q, p;
    logic [3:0] dly = 4'h0;
    logic [5:0] seen = 6'h00;
    hal_pkg::hal_frame_t rxf = '0, txf, last;
    hal_pkg::hal_irq_t   irq;
    int     err_total = 0, num_checks = 0, n_tx = 0, cyc = 0, t0;
    integer seed = 32'h0171_c021;
    logic [7:0] ra[7] = '{hal_pkg::A_MODE, hal_pkg::A_BCH, hal_pkg::A_SECOND_HIGH_ADDRESS_COMPARE, hal_pkg::A_PER,
                          hal_pkg::A_RTY, hal_pkg::A_CMD, 8'hFC};
    logic [7:0] rv[7] = '{hal_pkg::RST_MODE, hal_pkg::RST_BCH, hal_pkg::RST_SECOND_HIGH_ADDRESS_COMPARE,
                          hal_pkg::RST_PER, hal_pkg::RST_RTY, 8'h00, 8'h00};

    hal_link #(.TICK(TK)) i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .rx_valid_in(rxv), .rx_frame_in(rxf), .rx_store_out(store), .tx_start_out(start),
        .tx_frame_out(txf), .tx_done_in(done), .ctrl_ext_out(ext), .queue_locked_out(lock),
        .irq_out(irq));
    hal_framer_model i_far (.clk_in(clk_in), .rst_b_in(rst_b_in), .tx_start_in(start),
        .dly_in(dly), .tx_done_out(done));

    always #5 clk_in = ~clk_in;

    // pulses are made sticky so a check never hinges on hitting their one cycle
    always @(posedge clk_in) begin
        cyc++;
        if (start) begin
            last <= txf;
            n_tx <= n_tx + 1;
        end
        seen <= seen | {store, irq};
        if (cyc == 3000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic end_sim;
        if (err_total == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] fsum(input logic [1:0] k, input logic c);
        return {5'h00, k, c};
    endfunction : fsum

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic rx(input logic [1:0] k, input logic [1:0] sf, input logic [6:0] ns,
                      input logic [6:0] nr, input logic pf, input logic cmd);
        @(posedge clk_in);
        rxf <= {k, sf, ns, nr, pf, cmd, 1'b0};
        rxv <= 1'b1;
        dly <= 4'($random(seed));
        @(posedge clk_in);
        rxv <= 1'b0;
    endtask : rx

    task automatic wait_tx(input int lim);
        int n0;
        n0 = n_tx;
        repeat (lim) begin
            @(posedge clk_in);
            #1;
            if (n_tx != n0) return;
        end
        chk(8'h00, 8'h01);
    endtask : wait_tx

    initial begin
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        foreach (ra[i]) begin
            rd_reg(ra[i], q);
            chk(q, rv[i]);
        end
        wr_reg(hal_pkg::A_SECOND_HIGH_ADDRESS_COMPARE, 8'h01);
        #1 chk({7'h00, ext}, 8'h01);
        wr_reg(hal_pkg::A_SECOND_HIGH_ADDRESS_COMPARE, 8'h00);
        p = {5'h00, 3'($random(seed))} + 8'h01;
        wr_reg(hal_pkg::A_PER, p);
        wr_reg(8'hFC, 8'h55);
        rd_reg(hal_pkg::A_PER, q);
        chk(q, p);
        wr_reg(hal_pkg::A_PER, 8'h40);
        seen = 6'h00;
        rx(hal_pkg::K_U, 2'h0, 7'h00, 7'h00, 1'b0, 1'b1);
        @(posedge clk_in);
        #1 chk({2'h0, seen}, 8'h20);
        seen = 6'h00;
        wr_reg(hal_pkg::A_CMD, 8'h02);
        wait_tx(24);
        chk({6'h00, last.kind}, {6'h00, hal_pkg::K_T});
        repeat (20) @(posedge clk_in);
        #1 chk({2'h0, seen}, 8'h10);
        chk({7'h00, lock}, 8'h00);
        wr_reg(hal_pkg::A_MODE, 8'h08);
        wr_reg(hal_pkg::A_CMD, 8'h01);
        wait_tx(24);
        chk(fsum(last.kind, last.is_cmd), fsum(hal_pkg::K_I, 1'b1));
        repeat (18) @(posedge clk_in);
        #1 chk({7'h00, lock}, 8'h01);
        seen = 6'h00;
        rx(hal_pkg::K_S, hal_pkg::S_RR, 7'h00, {6'($random(seed)), 1'b1}, 1'b0, 1'b0);
        @(posedge clk_in);
        #1 chk({3'h0, seen[4:0]}, 8'h10);
        chk({7'h00, lock}, 8'h00);
        repeat (18) @(posedge clk_in);
        seen = 6'h00;
        rx(hal_pkg::K_I, 2'h0, 7'h01, 7'h01, 1'b0, 1'b1);
        wait_tx(hal_pkg::RESP_MAX_CYC);
        chk(fsum(last.kind, last.is_cmd), fsum(hal_pkg::K_S, 1'b0));
        chk({2'h0, seen}, 8'h00);
        wr_reg(hal_pkg::A_MODE, 8'h18);
        repeat (18) @(posedge clk_in);
        rx(hal_pkg::K_I, 2'h0, 7'h00, 7'h01, 1'b0, 1'b1);
        wait_tx(hal_pkg::RESP_MAX_CYC);
        chk({6'h00, last.sfunc}, {6'h00, hal_pkg::S_RNR});
        chk({2'h0, seen}, 8'h00);
        wr_reg(hal_pkg::A_MODE, 8'h08);
        wr_reg(hal_pkg::A_PER, 8'h02);
        wr_reg(hal_pkg::A_RTY, 8'h01);
        wr_reg(hal_pkg::A_CMD, 8'h01);
        wait_tx(24);
        wait_tx(60);
        chk(fsum(last.kind, last.is_cmd), fsum(hal_pkg::K_S, 1'b1));
        chk({7'h00, last.pf}, 8'h01);
        repeat (60) @(posedge clk_in);
        #1 chk({3'h0, seen[4:0]}, 8'h04);
        chk({7'h00, lock}, 8'h00);
        wr_reg(hal_pkg::A_CMD, 8'h04);
        rd_reg(hal_pkg::A_VS, q);
        chk(q, 8'h00);
        rx(hal_pkg::K_S, hal_pkg::S_RR, 7'h00, 7'h00, 1'b1, 1'b1);
        wait_tx(hal_pkg::RESP_MAX_CYC);
        chk(fsum(last.kind, last.is_cmd), fsum(hal_pkg::K_S, 1'b0));
        chk({7'h00, last.pf}, 8'h01);
        // secondary set-up: auto-mode, 8-bit address, external timer
        wr_reg(hal_pkg::A_MODE, 8'h00);
        wr_reg(hal_pkg::A_BCH, 8'h20);
        t0 = n_tx;
        wr_reg(hal_pkg::A_CMD, 8'h01);
        repeat (30) @(posedge clk_in);
        #1 chk(8'(n_tx - t0), 8'h00);
        rx(hal_pkg::K_S, hal_pkg::S_RR, 7'h00, 7'h00, 1'b1, 1'b1);
        wait_tx(8);
        chk(fsum(last.kind, last.is_cmd), fsum(hal_pkg::K_I, 1'b0));
        chk({7'h00, last.pf}, 8'h01);
        repeat (20) @(posedge clk_in);
        #1 chk({7'h00, lock}, 8'h01);
        seen = 6'h00;
        rx(hal_pkg::K_S, hal_pkg::S_RR, 7'h00, 7'h01, 1'b1, 1'b1);
        @(posedge clk_in);
        #1 chk({3'h0, seen[4:0]}, 8'h10);
        chk({7'h00, lock}, 8'h00);
        end_sim();
    end
endmodule : tb_hdlc_auto_mode_link_procedure
